// ### core/fwsp_host.sv
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fwsp_host #(
  parameter int ADDR_W = fwsp_pkg::ADDR_W,
  parameter int DATA_W = fwsp_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Avalon-MM slave
  input  wire logic [2:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Flash pins
  output logic      [ADDR_W-1:0] flash_addr,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic      [DATA_W-1:0] flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n
);
  fwsp_pkg::fwsp_state_e state_r;
  fwsp_pkg::fwsp_cmd_e   cmd_r;
  logic [1:0]        step_r;
  logic [3:0]        cnt_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] prev_r;
  logic              busy_r, done_r, fail_r, reject_r, lock_r, prot_r, stog_r, abort_r;
  logic              abort_req_r;
  logic              rvalid_r;
  logic [31:0]       readdata_r;
  logic [ADDR_W-1:0] addr_out_r;
  logic [DATA_W-1:0] dq_out_r;
  logic              dq_oe_r, ce_n_r, oe_n_r, we_n_r;

  // Register decode
  wire        wr_ctrl   = avs_write && (avs_address == fwsp_pkg::REG_CTRL);
  wire        wr_addr   = avs_write && (avs_address == fwsp_pkg::REG_ADDR) && !busy_r;
  wire        wr_wdata  = avs_write && (avs_address == fwsp_pkg::REG_WDATA) && !busy_r;
  wire [2:0]  new_cmd   = avs_writedata[fwsp_pkg::CTRL_CMD_LSB +: fwsp_pkg::CTRL_CMD_W];
  wire        abort_wr  = wr_ctrl && avs_writedata[fwsp_pkg::CTRL_ABORT_BIT];
  wire        start     = wr_ctrl && !busy_r && (new_cmd != fwsp_pkg::CMD_NONE);
  wire        is_write  = (new_cmd == fwsp_pkg::CMD_WRITE);
  wire        is_reset  = (wdata_r == fwsp_pkg::RESET_CMD);
  wire        refused   = start && is_write && lock_r && !is_reset;
  wire        start_wr  = start && is_write && !refused;
  wire        start_rd  = start && !is_write;
  wire [ADDR_W-1:0] bit_one = ADDR_W'(1) << fwsp_pkg::ADDRESS_BIT_ONE;
  wire [ADDR_W-1:0] start_addr =
    (new_cmd == fwsp_pkg::CMD_PROT) ? (addr_r | bit_one) : addr_r;
  wire        tog_same  = rdata_r[fwsp_pkg::TOGGLING_STATUS_BIT] ==
                          prev_r[fwsp_pkg::TOGGLING_STATUS_BIT];
  wire        stog_diff = rdata_r[fwsp_pkg::SECTOR_TOGGLE_BIT] ^
                          prev_r[fwsp_pkg::SECTOR_TOGGLE_BIT];
  wire        cnt_end   = (cnt_r == fwsp_pkg::CNT_LAST);
  wire [fwsp_pkg::ST_W-1:0] status_bits = {abort_r, stog_r, prot_r, lock_r,
                                           reject_r, fail_r, done_r, busy_r};
  wire [31:0] status_word = {24'h00_0000, status_bits};
  wire [31:0] rd_mux =
    (avs_address == fwsp_pkg::REG_CTRL)   ? {29'h0000_0000, cmd_r}               :
    (avs_address == fwsp_pkg::REG_ADDR)   ? {{(32-ADDR_W){1'b0}}, addr_r}         :
    (avs_address == fwsp_pkg::REG_WDATA)  ? {{(32-DATA_W){1'b0}}, wdata_r}        :
    (avs_address == fwsp_pkg::REG_STATUS) ? status_word                           :
    (avs_address == fwsp_pkg::REG_RDATA)  ? {{(32-DATA_W){1'b0}}, rdata_r}        :
                                            32'h0000_0000;

  assign avs_waitrequest = avs_read && !rvalid_r;
  assign avs_readdata    = readdata_r;
  assign flash_addr      = addr_out_r;
  assign flash_dq_out    = dq_out_r;
  assign flash_dq_oe     = dq_oe_r;
  assign flash_ce_n      = ce_n_r;
  assign flash_oe_n      = oe_n_r;
  assign flash_we_n      = we_n_r;

  // Decision after each completed bus cycle
  logic       dec_rd, dec_wr, dec_done, dec_fail, dec_reject, dec_abort, dec_save;
  logic [1:0] step_nxt;
  always_comb begin
    dec_rd     = 1'b0;
    dec_wr     = 1'b0;
    dec_done   = 1'b0;
    dec_fail   = 1'b0;
    dec_reject = 1'b0;
    dec_abort  = 1'b0;
    dec_save   = 1'b0;
    step_nxt   = step_r;
    unique case (cmd_r)
      fwsp_pkg::CMD_POLL: begin
        unique case (step_r)
          fwsp_pkg::STEP_0: begin
            dec_save = 1'b1;
            dec_rd   = 1'b1;
            step_nxt = fwsp_pkg::STEP_1;
          end
          fwsp_pkg::STEP_1: begin
            if (tog_same) begin
              dec_done = 1'b1;
            end else if (rdata_r[fwsp_pkg::TIMEOUT_FLAG]) begin
              dec_rd   = 1'b1;
              step_nxt = fwsp_pkg::STEP_2;
            end else if (abort_req_r) begin
              dec_abort = 1'b1;
              dec_done  = 1'b1;
            end else begin
              dec_save = 1'b1;
              dec_rd   = 1'b1;
            end
          end
          fwsp_pkg::STEP_2: begin
            dec_save = 1'b1;
            dec_rd   = 1'b1;
            step_nxt = fwsp_pkg::STEP_3;
          end
          fwsp_pkg::STEP_3: begin
            dec_done = 1'b1;
            dec_fail = !tog_same;
          end
        endcase
      end
      fwsp_pkg::CMD_ERADD: begin
        if (step_r == fwsp_pkg::STEP_0) begin
          if (rdata_r[fwsp_pkg::ERASE_WINDOW_FLAG]) begin
            dec_reject = 1'b1;
            dec_done   = 1'b1;
          end else begin
            dec_wr   = 1'b1;
            step_nxt = fwsp_pkg::STEP_1;
          end
        end else if (step_r == fwsp_pkg::STEP_1) begin
          dec_rd   = 1'b1;
          step_nxt = fwsp_pkg::STEP_2;
        end else begin
          dec_reject = rdata_r[fwsp_pkg::ERASE_WINDOW_FLAG];
          dec_done   = 1'b1;
        end
      end
      default: dec_done = 1'b1;
    endcase
  end

  wire in_dec = (state_r == fwsp_pkg::S_DEC);
  wire go_rd  = start_rd || (in_dec && dec_rd);
  wire go_wr  = start_wr || (in_dec && dec_wr);

  // Pin sequencing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r    <= fwsp_pkg::S_IDLE;
      cnt_r      <= 4'h0;
      ce_n_r     <= 1'b1;
      oe_n_r     <= 1'b1;
      we_n_r     <= 1'b1;
      dq_oe_r    <= 1'b0;
      dq_out_r   <= '0;
      addr_out_r <= '0;
      rdata_r    <= '0;
    end else begin
      if (start) begin
        addr_out_r <= start_addr;
      end
      unique case (state_r)
        fwsp_pkg::S_IDLE, fwsp_pkg::S_DEC: begin
          if (go_rd) begin
            state_r <= fwsp_pkg::S_RD;
            cnt_r   <= fwsp_pkg::RD_CYC;
            ce_n_r  <= 1'b0;
            oe_n_r  <= 1'b0;
          end else if (go_wr) begin
            state_r  <= fwsp_pkg::S_WR;
            cnt_r    <= fwsp_pkg::WP_CYC;
            ce_n_r   <= 1'b0;
            we_n_r   <= 1'b0;
            dq_oe_r  <= 1'b1;
            dq_out_r <= wdata_r;
          end else begin
            state_r <= fwsp_pkg::S_IDLE;
          end
        end
        fwsp_pkg::S_RD: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_end) begin
            rdata_r <= flash_dq_in;
            ce_n_r  <= 1'b1;
            oe_n_r  <= 1'b1;
            cnt_r   <= fwsp_pkg::GAP_CYC;
            state_r <= fwsp_pkg::S_GAP;
          end
        end
        fwsp_pkg::S_WR: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_end) begin
            ce_n_r  <= 1'b1;
            we_n_r  <= 1'b1;
            cnt_r   <= fwsp_pkg::GAP_CYC;
            state_r <= fwsp_pkg::S_GAP;
          end
        end
        fwsp_pkg::S_GAP: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_end) begin
            dq_oe_r <= 1'b0;
            state_r <= fwsp_pkg::S_DEC;
          end
        end
        default: state_r <= fwsp_pkg::S_IDLE;
      endcase
    end
  end

  // Command and status
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_r       <= fwsp_pkg::CMD_NONE;
      step_r      <= fwsp_pkg::STEP_0;
      prev_r      <= '0;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      fail_r      <= 1'b0;
      reject_r    <= 1'b0;
      lock_r      <= 1'b0;
      prot_r      <= 1'b0;
      stog_r      <= 1'b0;
      abort_r     <= 1'b0;
      abort_req_r <= 1'b0;
    end else if (start) begin
      cmd_r       <= fwsp_pkg::fwsp_cmd_e'(new_cmd);
      step_r      <= fwsp_pkg::STEP_0;
      busy_r      <= !refused;
      done_r      <= refused;
      fail_r      <= 1'b0;
      reject_r    <= refused;
      abort_r     <= 1'b0;
      abort_req_r <= 1'b0;
      if (start_wr && is_reset) begin
        lock_r <= 1'b0;
      end
    end else begin
      if (abort_wr && busy_r) begin
        abort_req_r <= 1'b1;
      end
      if (in_dec) begin
        step_r <= step_nxt;
        if (dec_save) begin
          prev_r <= rdata_r;
        end
        if (cmd_r == fwsp_pkg::CMD_POLL && step_r != fwsp_pkg::STEP_0) begin
          stog_r <= stog_diff;
        end
        if (dec_done) begin
          busy_r   <= 1'b0;
          done_r   <= 1'b1;
          fail_r   <= dec_fail;
          reject_r <= dec_reject;
          abort_r  <= dec_abort;
          prot_r   <= rdata_r[fwsp_pkg::LSB_DATA_BIT];
          if (dec_fail) begin
            lock_r <= 1'b1;
          end
        end
      end
    end
  end

  // Address and data registers, bus answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_r     <= '0;
      wdata_r    <= '0;
      rvalid_r   <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      if (wr_addr) begin
        addr_r <= avs_writedata[ADDR_W-1:0];
      end
      if (wr_wdata) begin
        wdata_r <= avs_writedata[DATA_W-1:0];
      end
      rvalid_r <= avs_read && !rvalid_r;
      if (avs_read && !rvalid_r) begin
        readdata_r <= rd_mux;
      end
    end
  end
endmodule // fwsp_host
`default_nettype wire

// ### core/fwsp_pkg.sv
// Overview of operation
// - Host reads twice back to back; unchanged toggle bit means finished.
// - Still toggling: check timeout flag; if high recheck; still toggling means failure.
// - Host resuming interrupted polling restarts from the first two reads.
// - With timeout flag set, host must issue reset before further program or erase; the code refuses only CMD_WRITE while lock_r is set, CMD_ERADD still runs.
// - Host reads erase window flag before and after each added sector erase.
// - Write only with chip select low, write strobe low, output enable high.
package fwsp_pkg;
  // Timing, ns and derived cycles
  localparam int CLK_NS   = 8;
  localparam int T_RD_NS  = 90;
  localparam int T_WP_NS  = 35;
  localparam int T_GAP_NS = 20;
  localparam logic [3:0] RD_CYC  = 4'((T_RD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WP_CYC  = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] GAP_CYC = 4'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CNT_LAST = 4'h1;
  // Widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  // Register word indices
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_ADDR   = 3'h1;
  localparam logic [2:0] REG_WDATA  = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RDATA  = 3'h4;
  // Control fields
  localparam int CTRL_CMD_LSB   = 0;
  localparam int CTRL_CMD_W     = 3;
  localparam int CTRL_ABORT_BIT = 7;
  // Status fields
  localparam int ST_BUSY   = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_FAIL   = 2;
  localparam int ST_REJECT = 3;
  localparam int ST_LOCK   = 4;
  localparam int ST_PROT   = 5;
  localparam int ST_STOG   = 6;
  localparam int ST_ABORT  = 7;
  localparam int ST_W      = 8;
  // Flash status bit positions
  localparam int TOGGLING_STATUS_BIT = 6;
  localparam int SECTOR_TOGGLE_BIT   = 2;
  localparam int TIMEOUT_FLAG        = 5;
  localparam int ERASE_WINDOW_FLAG   = 3;
  localparam int LSB_DATA_BIT        = 0;
  localparam int ADDRESS_BIT_ONE     = 1;
  localparam logic [7:0] RESET_CMD   = 8'hF0;
  localparam logic [1:0] STEP_0 = 2'h0;
  localparam logic [1:0] STEP_1 = 2'h1;
  localparam logic [1:0] STEP_2 = 2'h2;
  localparam logic [1:0] STEP_3 = 2'h3;
  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_READ  = 3'b001,
    CMD_WRITE = 3'b010,
    CMD_POLL  = 3'b011,
    CMD_ERADD = 3'b100,
    CMD_PROT  = 3'b101
  } fwsp_cmd_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD   = 3'b001,
    S_WR   = 3'b010,
    S_GAP  = 3'b011,
    S_DEC  = 3'b100
  } fwsp_state_e;
endpackage

// ### verification/fwsp_props.sv
`timescale 1ns/1ps
`default_nettype none
module fwsp_props #(
  parameter int ADDR_W = fwsp_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst,
  // Bus handshake
  input wire logic              avs_read,
  input wire logic              avs_waitrequest,
  // Flash pins
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n
);
  logic [3:0] rd_len_r;
  logic [3:0] wr_len_r;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Strobe length counters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_len_r <= 4'h0;
      wr_len_r <= 4'h0;
    end else begin
      rd_len_r <= flash_oe_n ? 4'h0 : rd_len_r + 4'h1;
      wr_len_r <= flash_we_n ? 4'h0 : wr_len_r + 4'h1;
    end
  end
  sequence s_rd_open; $fell(flash_oe_n) && !flash_ce_n; endsequence
  sequence s_rd_hold; (!flash_oe_n && !flash_ce_n && flash_we_n)[*8]; endsequence
  property p_rd_hold; s_rd_open |-> s_rd_hold; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read strobe cut short");
  property p_rd_len; $rose(flash_oe_n) |-> rd_len_r == fwsp_pkg::RD_CYC; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
  property p_wr_len; $rose(flash_we_n) |-> wr_len_r == fwsp_pkg::WP_CYC; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write pulse length wrong");
  property p_inhibit; !flash_we_n |-> flash_oe_n && !flash_ce_n && flash_dq_oe; endproperty
  a_inhibit: assert property (p_inhibit) else $error("write strobe without qualifiers");
  property p_no_clash; !flash_oe_n |-> !flash_dq_oe; endproperty
  a_no_clash: assert property (p_no_clash) else $error("host drives data during read");
  property p_dq_release; $rose(flash_we_n) |-> ##[1:3] !flash_dq_oe; endproperty
  a_dq_release: assert property (p_dq_release) else $error("data bus not released");
  property p_gap; $rose(flash_ce_n) |-> flash_ce_n[*3]; endproperty
  a_gap: assert property (p_gap) else $error("gap between cycles too short");
  property p_addr_held; !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr); endproperty
  a_addr_held: assert property (p_addr_held) else $error("address moved in cycle");
  property p_rd_wait; avs_read && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait too long");
endmodule // fwsp_props
`default_nettype wire

// ### verification/fwsp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fwsp_flash_model (
  // Flash pins
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  // Scenario controls
  input  wire logic [7:0]  arr,
  input  wire logic [31:0] busy_until,
  input  wire logic        tmo,
  input  wire logic        ewin,
  input  wire logic        prot,
  input  wire logic        id_mode
);
  logic [31:0] reads = 32'h0000_0000;
  int          strobes = 0;
  int          writes = 0;
  logic [7:0]  wdata = 8'h00;
  logic        tog = 1'b0;
  logic [7:0]  last = 8'h00;
  realtime     t0 = 0.0;
  wire         busy = reads < busy_until;
  wire         rlow = !ce_n && !oe_n;
  wire         wlow = !ce_n && !we_n && oe_n;
  wire   [7:0] stat = {~arr[7], tog, tmo, 1'b0, ewin, tog, 2'b00};
  wire   [7:0] cur = busy ? stat : ((id_mode && addr[1]) ? {7'h00, prot} : arr);
  assign dq_out = rlow ? cur : ~last;
  // Toggle advances at end of each read while busy
  always @(negedge rlow) begin
    last = cur;
    if (busy) tog = ~tog;
    reads = reads + 32'h0000_0001;
  end
  always @(posedge wlow) t0 = $realtime;
  // Short pulses, refused sectors and closed window never write
  always @(negedge wlow) begin
    strobes++;
    if ($realtime - t0 >= 5.0 && !(busy && ewin) && !prot) begin
      wdata = dq_in;
      writes++;
    end
  end
endmodule // fwsp_flash_model
`default_nettype wire

// ### verification/fwsp_tb.sv
`timescale 1ns/1ps
`default_nettype none
bind fwsp_host fwsp_props #(.ADDR_W(ADDR_W)) fwsp_props_i (.clock(clock), .rst(rst),
  .avs_read(avs_read), .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n));
module testbench;
  logic        clock, rst, avs_read, avs_write, avs_waitrequest;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, busy_until;
  logic [18:0] flash_addr;
  logic [7:0]  flash_dq_in, flash_dq_out, mdl_dq, arr;
  logic        flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, tmo, ewin, prot, id_mode;
  int          error_cnt, total_checks, cyc, w0;
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : mdl_dq;
  fwsp_host fwsp_host_i (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_addr(flash_addr),
    .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
  fwsp_flash_model fwsp_flash_model_i (.addr(flash_addr), .dq_in(flash_dq_in), .dq_out(mdl_dq),
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .arr(arr), .busy_until(busy_until),
    .tmo(tmo), .ewin(ewin), .prot(prot), .id_mode(id_mode));
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic rd, input logic [2:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic st(input logic [7:0] mask, input logic [7:0] exp);
    bus(1'b1, fwsp_pkg::REG_STATUS, 32'h0000_0000);
    chk({24'h00_0000, q[7:0] & mask}, {24'h00_0000, exp});
  endtask
  task automatic wait_idle();
    do begin
      bus(1'b1, fwsp_pkg::REG_STATUS, 32'h0000_0000);
    end while (q[fwsp_pkg::ST_BUSY] !== 1'b0);
  endtask
  task automatic run(input logic [2:0] cmd);
    bus(1'b0, fwsp_pkg::REG_CTRL, {29'h0000_0000, cmd});
    wait_idle();
  endtask
  task automatic busy_for(input logic [31:0] n);
    busy_until = fwsp_flash_model_i.reads + n;
  endtask
  task automatic t_read();
    chk({29'h0000_0000, flash_ce_n, flash_oe_n, flash_we_n}, 32'h0000_0007);
    st(8'hFF, 8'h00);
    bus(1'b0, fwsp_pkg::REG_ADDR, 32'h0001_2345);
    run(fwsp_pkg::CMD_READ);
    bus(1'b1, fwsp_pkg::REG_RDATA, 32'h0000_0000);
    chk(q, 32'h0000_00A4);
    chk({13'h0000, flash_addr}, 32'h0001_2345);
    st(8'h0F, 8'h02);
    bus(1'b1, fwsp_pkg::REG_CTRL, 32'h0000_0000);
    chk(q, {29'h0000_0000, fwsp_pkg::CMD_READ});
    bus(1'b1, fwsp_pkg::REG_ADDR, 32'h0000_0000);
    chk(q, 32'h0001_2345);
    $display("test read done");
  endtask
  task automatic t_write();
    w0 = fwsp_flash_model_i.writes;
    bus(1'b0, fwsp_pkg::REG_WDATA, 32'h0000_003C);
    run(fwsp_pkg::CMD_WRITE);
    chk({24'h00_0000, fwsp_flash_model_i.wdata}, 32'h0000_003C);
    chk(fwsp_flash_model_i.writes - w0, 32'h0000_0001);
    bus(1'b1, fwsp_pkg::REG_WDATA, 32'h0000_0000);
    chk(q, 32'h0000_003C);
    $display("test write done");
  endtask
  task automatic t_poll();
    busy_for(32'h0000_0005);
    run(fwsp_pkg::CMD_POLL);
    st(8'h5F, 8'h42);
    busy_for(32'h0000_03E8);
    tmo = 1'b1;
    run(fwsp_pkg::CMD_POLL);
    st(8'h1F, 8'h16);
    w0 = fwsp_flash_model_i.strobes;
    bus(1'b0, fwsp_pkg::REG_WDATA, 32'h0000_0055);
    run(fwsp_pkg::CMD_WRITE);
    st(8'h1B, 8'h1A);
    chk(fwsp_flash_model_i.strobes - w0, 32'h0000_0000);
    busy_for(32'h0000_0000);
    tmo = 1'b0;
    bus(1'b0, fwsp_pkg::REG_WDATA, {24'h00_0000, fwsp_pkg::RESET_CMD});
    run(fwsp_pkg::CMD_WRITE);
    st(8'h10, 8'h00);
    chk({24'h00_0000, fwsp_flash_model_i.wdata}, 32'h0000_00F0);
    $display("test poll done");
  endtask
  task automatic t_erase();
    busy_for(32'h0000_03E8);
    w0 = fwsp_flash_model_i.strobes;
    run(fwsp_pkg::CMD_ERADD);
    st(8'h0F, 8'h02);
    chk(fwsp_flash_model_i.strobes - w0, 32'h0000_0001);
    ewin = 1'b1;
    run(fwsp_pkg::CMD_ERADD);
    st(8'h0F, 8'h0A);
    chk(fwsp_flash_model_i.strobes - w0, 32'h0000_0001);
    ewin = 1'b0;
    bus(1'b0, fwsp_pkg::REG_CTRL, {29'h0000_0000, fwsp_pkg::CMD_POLL});
    repeat (3) bus(1'b1, fwsp_pkg::REG_STATUS, 32'h0000_0000);
    bus(1'b0, fwsp_pkg::REG_CTRL, 32'h0000_0080);
    wait_idle();
    st(8'h87, 8'h82);
    busy_for(32'h0000_0000);
    $display("test erase done");
  endtask
  task automatic t_prot();
    id_mode = 1'b1;
    prot = 1'b1;
    run(fwsp_pkg::CMD_PROT);
    st(8'h20, 8'h20);
    chk({31'h0000_0000, flash_addr[1]}, 32'h0000_0001);
    prot = 1'b0;
    run(fwsp_pkg::CMD_PROT);
    st(8'h20, 8'h00);
    $display("test prot done");
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, tmo, ewin, prot, id_mode} = 6'h00;
    avs_address = 3'h0;
    avs_writedata = 32'h0000_0000;
    arr = 8'hA4;
    busy_until = 32'h0000_0000;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_read();
    t_write();
    t_poll();
    t_erase();
    t_prot();
    final_report();
  end
endmodule // testbench
`default_nettype wire
